// ===== pkg/urtc_pkg.sv
// Constants, register map and field layout of the up/down reload timer
package urtc_pkg;

  // Register byte addresses on the Wishbone bus
  localparam logic [7:0] ADR_CONTROL = 8'hc8;
  localparam logic [7:0] ADR_MODE = 8'hcc;
  localparam logic [7:0] ADR_COUNT_LOW = 8'hd0;
  localparam logic [7:0] ADR_COUNT_HIGH = 8'hd4;
  localparam logic [7:0] ADR_RELOAD_LOW = 8'hd8;
  localparam logic [7:0] ADR_RELOAD_HIGH = 8'hdc;
  localparam logic [7:0] ADR_BIT_ACCESS = 8'he0;

  // Control register bit positions
  localparam int CTL_OVERFLOW_FLAG = 7;
  localparam int CTL_EXTERNAL_FLAG = 6;
  localparam int CTL_RX_CLK_SEL = 5;
  localparam int CTL_TX_CLK_SEL = 4;
  localparam int CTL_EXTERNAL_EN = 3;
  localparam int CTL_RUN_EN = 2;
  localparam int CTL_SOURCE_SEL = 1;
  localparam int CTL_CAPTURE = 0;

  // Mode register bit positions
  localparam int MOD_CLOCK_OUT_EN = 1;
  localparam int MOD_UPDOWN_EN = 0;

  // Bit access register fields: index in [2:0], value in [3]
  localparam int BIT_VALUE_POS = 3;

  // Reset values and count limits
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // Control register as a packed group of its fields
  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic serial_rx_clock_select;
    logic serial_tx_clock_select;
    logic external_enable;
    logic run_enable;
    logic count_source_select;
    logic capture_not_reload;
  } urtc_ctrl_t;

  // Mode register fields
  typedef struct packed {
    logic clock_out_enable;
    logic updown_enable;
  } urtc_mode_t;

endpackage : urtc_pkg

// ===== hdl/urtc_timer.sv
// Up/down auto-reload timer with capture, baud tick and clock output
// What this block does
// - see: Count is two cascaded bytes; low byte carries into high byte while running.
// - see: Source select clear counts clock; set counts falling edges on clock pin.
// - see: Capture, auto-reload and baud modes chosen by serial selects and capture bit.
// - see: Auto-reload counts up unless updown enabled; then direction pin sets direction.
// - see: Counting up, passing FFFFh sets overflow flag, interrupts, loads reload value.
// - see: Counting down, count equal to reload sets overflow flag and loads FFFFh.
// - see: Updown mode toggles external flag per wrap; it never interrupts there.
// - see: Clock-out counts at half clock rate, toggling clock pin per overflow.
// - see: Clock-out overflows reload the count and raise no interrupt.
// - see: Clock-out frequency is clock over four times (65536 minus reload).
// - see: Baud generation and clock-out may run together from one reload value.
// - see: Overflow flag set only with both serial selects zero; software clears it.
// - see: External enable sets external flag on trigger capture or reload.
// - see: Serial selects route this overflow to serial rx/tx, else timer 1.
// - see: Trigger edge acts only when external enable set and not clocking serial.
// - see: Run enable starts and stops counting; count holds while stopped unless a trigger edge reloads it.
// - see: Serial selects force auto-reload; else capture bit picks capture or reload.
// - see: Control register resets to zero and allows single-bit set and clear.
// - see: Mode register holds clock-out in bit 1, updown in bit 0, reset zero.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module urtc_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // External pins
  input wire logic clock_pin_i,
  output logic clock_pin_o,
  output logic clock_pin_oe_n_o,
  input wire logic direction_pin_i,
  // Serial port clocking
  input wire logic timer1_overflow_i,
  output logic serial_rx_tick_o,
  output logic serial_tx_tick_o,
  // Interrupt request level
  output logic irq_o
);

  // Registers
  urtc_pkg::urtc_ctrl_t ctrl;
  urtc_pkg::urtc_mode_t mode;
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] reload_low;
  logic [7:0] reload_high;
  logic clock_pin_prev;
  logic direction_pin_prev;
  logic half_phase;
  logic clk_out_level;

  // Derived signals
  logic [15:0] count;
  logic [15:0] reload;
  logic serial_mode;
  logic capture_mode;
  logic updown_mode;
  logic clock_out_mode;
  logic half_rate;
  logic count_tick;
  logic clock_pin_fall;
  logic trigger;
  logic count_up;
  logic wrap_event;
  logic load_reload;
  logic load_max;
  logic roll_zero;
  logic [15:0] next_count;
  logic bus_write;
  logic bus_req;

  // Address match for a write on the low byte lane
  function automatic logic wr_hit(input logic [7:0] adr, input logic [7:0] target);
    return adr == target;
  endfunction : wr_hit

  // Apply a single-bit set or clear to the control byte
  function automatic logic [7:0] bit_apply(input logic [7:0] cur, input logic [3:0] op);
    logic [7:0] res;
    res = cur;
    res[op[2:0]] = op[urtc_pkg::BIT_VALUE_POS];
    return res;
  endfunction : bit_apply

  assign count = {count_high_byte, count_low_byte};
  assign reload = {reload_high, reload_low};

  // Mode decode
  assign serial_mode = ctrl.serial_rx_clock_select | ctrl.serial_tx_clock_select;
  assign capture_mode = ctrl.capture_not_reload & ~serial_mode;
  assign updown_mode = mode.updown_enable & ~capture_mode & ~serial_mode;
  assign clock_out_mode = mode.clock_out_enable & ~ctrl.count_source_select;
  assign half_rate = serial_mode | clock_out_mode;

  // Input event detection on the synchronous pins
  assign clock_pin_fall = clock_pin_prev & ~clock_pin_i;
  assign trigger = ctrl.external_enable & ~serial_mode & ~updown_mode
                   & direction_pin_prev & ~direction_pin_i;

  // Count enable from the selected source
  always_comb begin
    if (!ctrl.run_enable) begin
      count_tick = 1'b0;
    end else if (ctrl.count_source_select) begin
      count_tick = clock_pin_fall;
    end else if (half_rate) begin
      count_tick = half_phase;
    end else begin
      count_tick = 1'b1;
    end
  end

  // Direction and wrap decisions
  assign count_up = ~updown_mode | direction_pin_i;
  assign load_max = count_tick & ~count_up & (count == reload);
  assign roll_zero = count_tick & count_up & (count == urtc_pkg::COUNT_MAX) & capture_mode;
  assign load_reload = (count_tick & count_up & (count == urtc_pkg::COUNT_MAX) & ~capture_mode)
                       | (trigger & ~capture_mode);
  assign wrap_event = count_tick & (count_up ? (count == urtc_pkg::COUNT_MAX)
                                             : (count == reload));

  // Next count value
  always_comb begin
    if (load_reload) begin
      next_count = reload;
    end else if (load_max) begin
      next_count = urtc_pkg::COUNT_MAX;
    end else if (roll_zero) begin
      next_count = urtc_pkg::COUNT_RESET;
    end else if (count_tick && count_up) begin
      next_count = count + 16'h0001;
    end else if (count_tick) begin
      next_count = count - 16'h0001;
    end else begin
      next_count = count;
    end
  end

  // Bus request qualifiers
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_write = bus_req & wb_ack_o & wb_we_i & wb_sel_i[0];

  // Wishbone acknowledge, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  // Read data, latched together with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_ack_o) begin
      case (wb_adr_i)
        urtc_pkg::ADR_CONTROL: wb_dat_o <= {24'h000000, ctrl};
        urtc_pkg::ADR_MODE: wb_dat_o <= {30'h0, mode};
        urtc_pkg::ADR_COUNT_LOW: wb_dat_o <= {24'h000000, count_low_byte};
        urtc_pkg::ADR_COUNT_HIGH: wb_dat_o <= {24'h000000, count_high_byte};
        urtc_pkg::ADR_RELOAD_LOW: wb_dat_o <= {24'h000000, reload_low};
        urtc_pkg::ADR_RELOAD_HIGH: wb_dat_o <= {24'h000000, reload_high};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Control register: bus writes, then hardware flag events win
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= urtc_pkg::CONTROL_RESET;
    end else begin
      urtc_pkg::urtc_ctrl_t nc;
      nc = ctrl;
      if (bus_write && wr_hit(wb_adr_i, urtc_pkg::ADR_CONTROL)) begin
        nc = wb_dat_i[7:0];
      end else if (bus_write && wr_hit(wb_adr_i, urtc_pkg::ADR_BIT_ACCESS)) begin
        nc = bit_apply(ctrl, wb_dat_i[3:0]);
      end
      if (wrap_event && !serial_mode && !clock_out_mode) begin
        nc.overflow_flag = 1'b1;
      end
      if (wrap_event && updown_mode) begin
        nc.external_flag = ~ctrl.external_flag;
      end else if (trigger) begin
        nc.external_flag = 1'b1;
      end
      ctrl <= nc;
    end
  end

  // Mode register, low two bits only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= urtc_pkg::MODE_RESET;
    end else if (bus_write && wr_hit(wb_adr_i, urtc_pkg::ADR_MODE)) begin
      mode <= wb_dat_i[1:0];
    end
  end

  // Count bytes: software write overrides hardware counting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_low_byte <= urtc_pkg::COUNT_RESET[7:0];
    end else if (bus_write && wr_hit(wb_adr_i, urtc_pkg::ADR_COUNT_LOW)) begin
      count_low_byte <= wb_dat_i[7:0];
    end else begin
      count_low_byte <= next_count[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_high_byte <= urtc_pkg::COUNT_RESET[15:8];
    end else if (bus_write && wr_hit(wb_adr_i, urtc_pkg::ADR_COUNT_HIGH)) begin
      count_high_byte <= wb_dat_i[7:0];
    end else begin
      count_high_byte <= next_count[15:8];
    end
  end

  // Reload bytes: software write or capture of the running count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reload_low <= urtc_pkg::COUNT_RESET[7:0];
    end else if (trigger && capture_mode) begin
      reload_low <= count_low_byte;
    end else if (bus_write && wr_hit(wb_adr_i, urtc_pkg::ADR_RELOAD_LOW)) begin
      reload_low <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reload_high <= urtc_pkg::COUNT_RESET[15:8];
    end else if (trigger && capture_mode) begin
      reload_high <= count_high_byte;
    end else if (bus_write && wr_hit(wb_adr_i, urtc_pkg::ADR_RELOAD_HIGH)) begin
      reload_high <= wb_dat_i[7:0];
    end
  end

  // Pin history for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_pin_prev <= 1'b0;
      direction_pin_prev <= 1'b0;
    end else begin
      clock_pin_prev <= clock_pin_i;
      direction_pin_prev <= direction_pin_i;
    end
  end

  // Divide-by-two phase for baud and clock-out counting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_phase <= 1'b0;
    end else if (ctrl.run_enable && half_rate) begin
      half_phase <= ~half_phase;
    end else begin
      half_phase <= 1'b0;
    end
  end

  // Clock output level toggles on each overflow in clock-out mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_out_level <= 1'b0;
    end else if (!mode.clock_out_enable) begin
      clk_out_level <= 1'b0;
    end else if (wrap_event && clock_out_mode) begin
      clk_out_level <= ~clk_out_level;
    end
  end

  // Pin and serial outputs
  assign clock_pin_o = clk_out_level;
  assign clock_pin_oe_n_o = ~mode.clock_out_enable;
  assign serial_rx_tick_o = ctrl.serial_rx_clock_select ? wrap_event
                                                        : timer1_overflow_i;
  assign serial_tx_tick_o = ctrl.serial_tx_clock_select ? wrap_event
                                                        : timer1_overflow_i;
  assign irq_o = ctrl.overflow_flag | (ctrl.external_flag & ~mode.updown_enable);

  // Acknowledge is a single-cycle pulse
  a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // Stopped timer keeps its count
  a_hold_when_stopped: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl.run_enable && !bus_write) |=> (count == $past(count)))
    else $error("count moved while stopped");

  // Overflow flag set after an up or down wrap outside serial and clock-out modes
  a_overflow_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (wrap_event && !serial_mode && !clock_out_mode) |=> ctrl.overflow_flag)
    else $error("overflow flag not set on wrap");

  // Up wrap in reload mode loads the reload value
  a_up_wrap_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    (count_tick && count_up && count == 16'hffff && !capture_mode && !bus_write)
    |=> (count == $past(reload)))
    else $error("reload not loaded on overflow");

  // Down wrap loads all ones
  a_down_wrap_max: assert property (@(posedge clk_i) disable iff (rst_i)
    (count_tick && !count_up && count == reload && !bus_write) |=> (count == 16'hffff))
    else $error("underflow did not load FFFFh");

  // Updown wrap toggles the external flag
  a_updown_toggle_ext: assert property (@(posedge clk_i) disable iff (rst_i)
    (wrap_event && updown_mode && !bus_write) |=> (ctrl.external_flag != $past(ctrl.external_flag)))
    else $error("external flag did not toggle");

  // Clock output toggles on overflow in clock-out mode
  a_clock_out_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    (wrap_event && clock_out_mode && mode.clock_out_enable) |=> (clock_pin_o != $past(clock_pin_o)))
    else $error("clock pin did not toggle");

  // Half rate: never two counts in consecutive cycles
  a_half_rate_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (count_tick && half_rate && !ctrl.count_source_select) |=> !count_tick)
    else $error("half rate counted twice in a row");

  // Capture copies the count into the reload bytes
  a_capture_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    (trigger && capture_mode) |=> (reload == $past(count)))
    else $error("capture did not copy count");

  // Disabled external input never raises the external flag
  a_ext_disabled_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl.external_flag && !ctrl.external_enable && !updown_mode && !bus_write)
    |=> !ctrl.external_flag)
    else $error("external flag set while disabled");

endmodule : urtc_timer
`default_nettype wire

// ===== verif/urtc_far_side.sv
// Model of the external count, trigger pins and serial port side
`timescale 1ns/1ps
`default_nettype none

module urtc_far_side (
  // Clock
  input wire logic clk_i,
  // From the timer
  input wire logic rx_tick_i,
  input wire logic tx_tick_i,
  input wire logic clk_out_i,
  // To the timer
  output logic count_pin_o,
  output logic dir_pin_o,
  output logic t1_ovf_o
);
  int rx_cnt = 0;
  int tx_cnt = 0;
  int hi_run = 0;
  int hi_len = 0;

  // Pins idle high, timer 1 quiet
  initial begin
    count_pin_o = 1'b1;
    dir_pin_o = 1'b1;
    t1_ovf_o = 1'b0;
  end

  // Serial side tick counts and clock-out high time
  always @(posedge clk_i) begin
    if (rx_tick_i === 1'b1) rx_cnt <= rx_cnt + 1;
    if (tx_tick_i === 1'b1) tx_cnt <= tx_cnt + 1;
    if (clk_out_i === 1'b1) begin
      hi_run <= hi_run + 1;
    end else if (hi_run != 0) begin
      hi_len <= hi_run;
      hi_run <= 0;
    end
  end

  // Falling edges on the count pin, two cycles per level
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_i);
      count_pin_o <= 1'b0;
      repeat (2) @(posedge clk_i);
      count_pin_o <= 1'b1;
      @(posedge clk_i);
    end
  endtask : pulse

  // Direction or trigger level
  task automatic set_dir(input logic v);
    @(posedge clk_i);
    dir_pin_o <= v;
  endtask : set_dir

  // One-cycle timer 1 overflow pulses
  task automatic t1_pulse(input int n);
    repeat (n) begin
      @(posedge clk_i);
      t1_ovf_o <= 1'b1;
      @(posedge clk_i);
      t1_ovf_o <= 1'b0;
    end
  endtask : t1_pulse
endmodule : urtc_far_side
`default_nettype wire

// ===== verif/urtc_timer_tb.sv
// Self-checking bench for the up/down reload timer
`timescale 1ns/1ps
`default_nettype none

module urtc_timer_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h1;
  logic [3:0] lane = 4'h1;
  logic [31:0] rdat;
  logic ack, cpo, oe_n, dpin, cpin, t1, rxt, txt, irq;
  logic [7:0] q, q2;
  int error_cnt = 0;
  int checked = 0;

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  urtc_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .clock_pin_i(cpin), .clock_pin_o(cpo), .clock_pin_oe_n_o(oe_n),
    .direction_pin_i(dpin), .timer1_overflow_i(t1), .serial_rx_tick_o(rxt),
    .serial_tx_tick_o(txt), .irq_o(irq));

  urtc_far_side far (.clk_i(clk_i), .rx_tick_i(rxt), .tx_tick_i(txt), .clk_out_i(cpo),
    .count_pin_o(cpin), .dir_pin_o(dpin), .t1_ovf_o(t1));

  // Classic single Wishbone cycle, held until ack; only the watchdog ends a wait
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lane;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle

  // Single control bit through the bit access register
  task automatic setb(input int idx, input logic v);
    wb(8'he0, 1'b1, {4'h0, v, idx[2:0]});
  endtask : setb

  task automatic put16(input logic [7:0] lo_adr, input logic [15:0] v);
    wb(lo_adr, 1'b1, v[7:0]);
    wb(lo_adr + 8'h04, 1'b1, v[15:8]);
  endtask : put16

  task automatic t_reset;
    wb(8'hc8, 1'b0, 8'h00);
    chk("ctl_rst", 8'h00, q);
    wb(8'hcc, 1'b0, 8'h00);
    chk("mode_rst", 8'h00, q);
    wb(8'h00, 1'b0, 8'h00);
    chk("unmapped", 8'h00, q);
    setb(3, 1'b1);
    wb(8'hc8, 1'b0, 8'h00);
    chk("bit_set", 8'h08, q);
    setb(3, 1'b0);
    wb(8'hc8, 1'b0, 8'h00);
    chk("bit_clr", 8'h00, q);
    // Write with byte lane 0 off must leave the register alone
    lane = 4'h0;
    wb(8'hd8, 1'b1, 8'h5a);
    lane = 4'h1;
    wb(8'hd8, 1'b0, 8'h00);
    chk("lane_off", 8'h00, q);
  endtask : t_reset

  task automatic t_overflow;
    put16(8'hd8, 16'h1234);
    put16(8'hd0, 16'hfff0);
    setb(2, 1'b1);
    idle(40);
    setb(2, 1'b0);
    wb(8'hc8, 1'b0, 8'h00);
    chk("ovf_flag", 8'h80, q);
    chk("ovf_irq", 8'h01, {7'h0, irq});
    wb(8'hd4, 1'b0, 8'h00);
    chk("ovf_reload", 8'h12, q);
    wb(8'hd0, 1'b0, 8'h00);
    q2 = q;
    idle(10);
    wb(8'hd0, 1'b0, 8'h00);
    chk("stop_hold", q2, q);
    setb(7, 1'b0);
    idle(1);
    chk("sw_clear", 8'h00, {7'h0, irq});
  endtask : t_overflow

  task automatic t_down;
    wb(8'hcc, 1'b1, 8'h01);
    far.set_dir(1'b0);
    put16(8'hd8, 16'h0010);
    put16(8'hd0, 16'h0018);
    setb(2, 1'b1);
    idle(20);
    setb(2, 1'b0);
    wb(8'hc8, 1'b0, 8'h00);
    chk("down_flags", 8'hc0, q);
    wb(8'hd4, 1'b0, 8'h00);
    chk("down_ffff", 8'hff, q);
    setb(7, 1'b0);
    idle(1);
    chk("toggle_noirq", 8'h00, {7'h0, irq});
    setb(6, 1'b0);
    wb(8'hcc, 1'b1, 8'h00);
    far.set_dir(1'b1);
  endtask : t_down

  task automatic t_capture;
    put16(8'hd8, 16'h0000);
    put16(8'hd0, 16'h0100);
    wb(8'hc8, 1'b1, 8'h0d);
    idle(8);
    far.set_dir(1'b0);
    idle(8);
    setb(2, 1'b0);
    wb(8'hc8, 1'b0, 8'h00);
    chk("cap_flag", 8'h49, q);
    chk("cap_irq", 8'h01, {7'h0, irq});
    wb(8'hdc, 1'b0, 8'h00);
    chk("cap_high", 8'h01, q);
    wb(8'hd8, 1'b0, 8'h00);
    q2 = q;
    wb(8'hd0, 1'b0, 8'h00);
    chk("cap_goes_on", 8'h01, {7'h0, q > q2});
    wb(8'hc8, 1'b1, 8'h00);
    far.set_dir(1'b1);
  endtask : t_capture

  // Trigger edge reloads in reload mode, and is ignored with external enable clear
  task automatic t_ext_reload;
    put16(8'hd8, 16'h0200);
    put16(8'hd0, 16'h0050);
    wb(8'hc8, 1'b1, 8'h0c);
    idle(4);
    far.set_dir(1'b0);
    idle(4);
    setb(2, 1'b0);
    wb(8'hc8, 1'b0, 8'h00);
    chk("trig_flag", 8'h48, q);
    chk("trig_irq", 8'h01, {7'h0, irq});
    wb(8'hd4, 1'b0, 8'h00);
    chk("trig_reload", 8'h02, q);
    wb(8'hc8, 1'b1, 8'h00);
    far.set_dir(1'b1);
    wb(8'hc8, 1'b1, 8'h04);
    far.set_dir(1'b0);
    idle(2);
    wb(8'hc8, 1'b0, 8'h00);
    chk("trig_ignored", 8'h04, q);
    wb(8'hc8, 1'b1, 8'h00);
    far.set_dir(1'b1);
  endtask : t_ext_reload

  task automatic t_clock_out;
    wb(8'hcc, 1'b1, 8'h02);
    idle(1);
    chk("oe_low", 8'h00, {7'h0, oe_n});
    put16(8'hd8, 16'hfffd);
    put16(8'hd0, 16'hfffd);
    setb(2, 1'b1);
    idle(100);
    chk("half_period", 8'h06, far.hi_len[7:0]);
    wb(8'hc8, 1'b0, 8'h00);
    chk("co_noflag", 8'h04, q);
    wb(8'hc8, 1'b1, 8'h00);
    wb(8'hcc, 1'b1, 8'h00);
    idle(1);
    chk("oe_off", 8'h01, {7'h0, oe_n});
  endtask : t_clock_out

  // Baud ticks and clock output together from one reload value
  task automatic t_baud;
    int r0, t0;
    put16(8'hd8, 16'hfffe);
    put16(8'hd0, 16'hfffe);
    wb(8'hcc, 1'b1, 8'h02);
    r0 = far.rx_cnt;
    t0 = far.tx_cnt;
    wb(8'hc8, 1'b1, 8'h24);
    idle(400);
    far.t1_pulse(3);
    idle(1);
    r0 = far.rx_cnt - r0;
    chk("baud_rate", 8'h01, {7'h0, r0 > 98 && r0 < 110});
    chk("tx_timer1", 8'h03, 8'(far.tx_cnt - t0));
    chk("shared_half", 8'h04, far.hi_len[7:0]);
    wb(8'hc8, 1'b0, 8'h00);
    chk("baud_noflag", 8'h24, q);
    wb(8'hc8, 1'b1, 8'h00);
    wb(8'hcc, 1'b1, 8'h00);
  endtask : t_baud

  task automatic t_ext_count;
    put16(8'hd0, 16'h0000);
    wb(8'hc8, 1'b1, 8'h06);
    far.pulse(5);
    wb(8'hc8, 1'b1, 8'h00);
    wb(8'hd0, 1'b0, 8'h00);
    chk("ext_edges", 8'h05, q);
  endtask : t_ext_count

  task automatic results;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // Watchdog over the expected run length
  initial begin
    idle(8000);
    error_cnt++;
    results();
  end

  // Main sequence
  initial begin
    idle(6);
    rst_i <= 1'b0;
    t_reset();
    t_overflow();
    t_down();
    t_capture();
    t_ext_reload();
    t_clock_out();
    t_baud();
    t_ext_count();
    results();
  end
endmodule : urtc_timer_tb
`default_nettype wire
